// File: pkg/fault_bank_regs.vh
`ifndef FAULT_BANK_REGS_VH
`define FAULT_BANK_REGS_VH

// Register indices; byte address is four times the index
`define IDX_CONFIG_PARITY_FAULT 12'h53A
`define IDX_SELFTEST_FAULT 12'h53B
`define IDX_CELL_OVERVOLT_UPPER 12'h53C
`define IDX_CELL_OVERVOLT_LOWER 12'h53D
`define IDX_CELL_UNDERVOLT_UPPER 12'h53E
`define IDX_CELL_UNDERVOLT_LOWER 12'h53F
`define IDX_GPIO_OVERTEMP_STATUS 12'h540
`define IDX_IRQ_STATUS 12'h560
`define IDX_IRQ_ENABLE 12'h561
`define IDX_IRQ_CLEAR 12'h562

// config_parity_fault fields
`define BIT_VOLT_CFG_PARITY 0
`define BIT_TEMP_CFG_PARITY 1
`define MASK_CONFIG_PARITY 8'h03

// selftest_fault fields
`define BIT_UNDERVOLT_CMP 0
`define BIT_OVERVOLT_CMP 1
`define BIT_OVERTEMP_CMP 2
`define BIT_UNDERTEMP_CMP 3
`define BIT_VOLT_PATH 4
`define BIT_TEMP_PATH 5
`define BIT_SELFTEST_ABORTED 6
`define MASK_SELFTEST 8'h7F

// Interrupt event bits: one per fault group (OV and UV each cover two registers), plus self-test done and abort
`define IRQ_BITS 7
`define IRQ_CFG_PARITY 0
`define IRQ_SELFTEST 1
`define IRQ_OV 2
`define IRQ_UV 3
`define IRQ_OT 4
`define IRQ_SELFTEST_DONE 5
`define IRQ_SELFTEST_ABORT 6

`define RESET_BYTE 8'h00
`define RESET_IRQ 7'h00
`define RESET_WORD 32'h00000000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Bus field positions and reset values
`define ADDR_IDX_MSB 13
`define ADDR_IDX_LSB 2
`define IRQ_MSB 6
`define IRQ_LSB 0
`define BYTE_MSB 7
`define BYTE_LSB 0
`define STRB_BYTE0 0
`define RESET_IDX 12'h000
`define RESET_STRB 4'h0

`endif

// File: verilog/fault_byte_reg.v
`default_nettype none
`include "fault_bank_regs.vh"

// One 8-bit fault register: flags load from the detector when load is high, no software write path
module fault_byte_reg (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Update control
	input wire load,
	input wire [7:0] next_value,
	// Stored flags
	output wire [7:0] value
);

reg [7:0] value_ff;

always @(posedge aclk) begin
	if (!aresetn) begin
		value_ff <= `RESET_BYTE;
	end else if (load) begin
		value_ff <= next_value;
	end
end

assign value = value_ff;

endmodule // fault_byte_reg
`default_nettype wire

// File: verilog/irq_sticky.v
`default_nettype none
`include "fault_bank_regs.vh"

// Sticky event flags with enable gating; a new event beats a same-cycle clear
module irq_sticky (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Events and software control
	input wire [6:0] event_pulse,
	input wire [6:0] clear_mask,
	input wire [6:0] enable_mask,
	// Status and interrupt
	output wire [6:0] status,
	output wire irq
);

reg [6:0] status_ff;
wire [6:0] nxt_status;

assign nxt_status = (status_ff & ~clear_mask) | event_pulse;

always @(posedge aclk) begin
	if (!aresetn) begin
		status_ff <= `RESET_IRQ;
	end else begin
		status_ff <= nxt_status;
	end
end

assign status = status_ff;
assign irq = |(status_ff & enable_mask);

endmodule // irq_sticky
`default_nettype wire

// File: verilog/protection_fault_status_bank.v
`default_nettype none
`include "fault_bank_regs.vh"

// Summary of operation
// - Bit 0 of config_parity_fault is set when voltage-protection configuration parity fails.
// - The temperature-protection parity flag is set when temperature configuration parity fails.
// - During self-test, bit 5 flags a temperature path fault and bit 4 a voltage path fault.
// - During self-test, bits 3 to 0 flag undertemp, overtemp, overvolt and undervolt comparator failures.
// - Overvoltage flags per cell: cells 9-16 in the upper register, cells 1-8 in the lower.
// - Undervoltage flags per cell: cells 9-16 in the upper register, cells 1-8 in the lower.
// - Overtemperature flags per GPIO, GPIO n in bit n-1.
// - Every flag reads 1 for a fault, 0 otherwise, and resets to 0.
module protection_fault_status_bank (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [13:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [13:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// Configuration parity checkers
	input wire volt_cfg_parity_err,
	input wire temp_cfg_parity_err,
	// Self-test engine
	input wire selftest_done,
	input wire selftest_aborted,
	input wire temp_path_err,
	input wire volt_path_err,
	input wire undertemp_cmp_err,
	input wire overtemp_cmp_err,
	input wire overvolt_cmp_err,
	input wire undervolt_cmp_err,
	// Protection comparators
	input wire [15:0] cell_overvolt_flag,
	input wire [15:0] cell_undervolt_flag,
	input wire [7:0] gpio_overtemp_flag,
	// Interrupt
	output wire irq
);

// Write side state
reg aw_held_ff;
reg [11:0] aw_idx_ff;
reg w_held_ff;
reg [31:0] w_data_ff;
reg [3:0] w_strb_ff;
reg bvalid_ff;
reg [1:0] bresp_ff;

// Read side state
reg rvalid_ff;
reg [31:0] rdata_ff;
reg [1:0] rresp_ff;

// Software control
reg [6:0] irq_enable_ff;

// Next state, write side
reg nxt_aw_held;
reg [11:0] nxt_aw_idx;
reg nxt_w_held;
reg [31:0] nxt_w_data;
reg [3:0] nxt_w_strb;
reg nxt_bvalid;
reg [1:0] nxt_bresp;
reg [6:0] nxt_irq_enable;

// Next state, read side
reg nxt_rvalid;
reg [31:0] nxt_rdata;
reg [1:0] nxt_rresp;

// Self-test and parity result capture
reg [7:0] nxt_selftest;
reg [7:0] nxt_parity;

wire [7:0] parity_value;
wire [7:0] selftest_value;
wire [7:0] ov_upper_value;
wire [7:0] ov_lower_value;
wire [7:0] uv_upper_value;
wire [7:0] uv_lower_value;
wire [7:0] ot_value;
wire [6:0] irq_status;
wire [6:0] irq_events;
wire [6:0] irq_clear;
wire selftest_end;
wire write_fire;
wire [11:0] ar_idx;
reg [31:0] read_word;
reg read_hit;

// Parity flags track the checkers continuously
always @* begin
	nxt_parity = `RESET_BYTE;
	nxt_parity[`BIT_VOLT_CFG_PARITY] = volt_cfg_parity_err;
	nxt_parity[`BIT_TEMP_CFG_PARITY] = temp_cfg_parity_err;
end

// Self-test results are latched only when a run ends, so mid-run glitches never show
assign selftest_end = selftest_done | selftest_aborted;

always @* begin
	nxt_selftest = `RESET_BYTE;
	nxt_selftest[`BIT_TEMP_PATH] = temp_path_err;
	nxt_selftest[`BIT_VOLT_PATH] = volt_path_err;
	nxt_selftest[`BIT_UNDERTEMP_CMP] = undertemp_cmp_err;
	nxt_selftest[`BIT_OVERTEMP_CMP] = overtemp_cmp_err;
	nxt_selftest[`BIT_OVERVOLT_CMP] = overvolt_cmp_err;
	nxt_selftest[`BIT_UNDERVOLT_CMP] = undervolt_cmp_err;
	// Abort wins if both ends are reported together
	nxt_selftest[`BIT_SELFTEST_ABORTED] = selftest_aborted;
end

fault_byte_reg u_parity (
	.aclk(aclk),
	.aresetn(aresetn),
	.load(1'b1),
	.next_value(nxt_parity),
	.value(parity_value)
);

fault_byte_reg u_selftest (
	.aclk(aclk),
	.aresetn(aresetn),
	.load(selftest_end),
	.next_value(nxt_selftest),
	.value(selftest_value)
);

fault_byte_reg u_ov_upper (
	.aclk(aclk),
	.aresetn(aresetn),
	.load(1'b1),
	.next_value(cell_overvolt_flag[15:8]),
	.value(ov_upper_value)
);

fault_byte_reg u_ov_lower (
	.aclk(aclk),
	.aresetn(aresetn),
	.load(1'b1),
	.next_value(cell_overvolt_flag[7:0]),
	.value(ov_lower_value)
);

fault_byte_reg u_uv_upper (
	.aclk(aclk),
	.aresetn(aresetn),
	.load(1'b1),
	.next_value(cell_undervolt_flag[15:8]),
	.value(uv_upper_value)
);

fault_byte_reg u_uv_lower (
	.aclk(aclk),
	.aresetn(aresetn),
	.load(1'b1),
	.next_value(cell_undervolt_flag[7:0]),
	.value(uv_lower_value)
);

fault_byte_reg u_ot (
	.aclk(aclk),
	.aresetn(aresetn),
	.load(1'b1),
	.next_value(gpio_overtemp_flag),
	.value(ot_value)
);

// Interrupt events: level sources raise the sticky bit each cycle they stand
assign irq_events[`IRQ_CFG_PARITY] = |parity_value;
assign irq_events[`IRQ_SELFTEST] = |selftest_value[`BIT_TEMP_PATH:`BIT_UNDERVOLT_CMP];
assign irq_events[`IRQ_OV] = |{ov_upper_value, ov_lower_value};
assign irq_events[`IRQ_UV] = |{uv_upper_value, uv_lower_value};
assign irq_events[`IRQ_OT] = |ot_value;
assign irq_events[`IRQ_SELFTEST_DONE] = selftest_done & ~selftest_aborted;
assign irq_events[`IRQ_SELFTEST_ABORT] = selftest_aborted;

assign write_fire = aw_held_ff & w_held_ff & ~bvalid_ff;
// Clear acts only in the cycle the write is performed, so it never repeats
assign irq_clear = (write_fire && aw_idx_ff == `IDX_IRQ_CLEAR && w_strb_ff[`STRB_BYTE0]) ?
	w_data_ff[`IRQ_MSB:`IRQ_LSB] : `RESET_IRQ;

irq_sticky u_irq (
	.aclk(aclk),
	.aresetn(aresetn),
	.event_pulse(irq_events),
	.clear_mask(irq_clear),
	.enable_mask(irq_enable_ff),
	.status(irq_status),
	.irq(irq)
);

// Write channel: address and data taken in either order, one write in flight
assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;

// A held part blocks its channel until the response has been taken
always @* begin
	nxt_aw_held = aw_held_ff;
	nxt_aw_idx = aw_idx_ff;
	nxt_w_held = w_held_ff;
	nxt_w_data = w_data_ff;
	nxt_w_strb = w_strb_ff;
	nxt_bvalid = bvalid_ff;
	nxt_bresp = bresp_ff;
	nxt_irq_enable = irq_enable_ff;
	if (s_axi_awvalid && s_axi_awready) begin
		nxt_aw_held = 1'b1;
		nxt_aw_idx = s_axi_awaddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
	end
	if (s_axi_wvalid && s_axi_wready) begin
		nxt_w_held = 1'b1;
		nxt_w_data = s_axi_wdata;
		nxt_w_strb = s_axi_wstrb;
	end
	if (write_fire) begin
		nxt_aw_held = 1'b0;
		nxt_w_held = 1'b0;
		nxt_bvalid = 1'b1;
		// Fault registers accept the write with OKAY but store nothing
		case (aw_idx_ff)
			`IDX_IRQ_ENABLE: begin
				nxt_bresp = `RESP_OKAY;
				if (w_strb_ff[`STRB_BYTE0]) begin
					nxt_irq_enable = w_data_ff[`IRQ_MSB:`IRQ_LSB];
				end
			end
			`IDX_IRQ_CLEAR: begin
				nxt_bresp = `RESP_OKAY;
			end
			`IDX_CONFIG_PARITY_FAULT, `IDX_SELFTEST_FAULT, `IDX_CELL_OVERVOLT_UPPER,
			`IDX_CELL_OVERVOLT_LOWER, `IDX_CELL_UNDERVOLT_UPPER, `IDX_CELL_UNDERVOLT_LOWER,
			`IDX_GPIO_OVERTEMP_STATUS, `IDX_IRQ_STATUS: begin
				nxt_bresp = `RESP_OKAY;
			end
			default: begin
				nxt_bresp = `RESP_SLVERR;
			end
		endcase
	end else if (bvalid_ff && s_axi_bready) begin
		nxt_bvalid = 1'b0;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_held_ff <= 1'b0;
		aw_idx_ff <= `RESET_IDX;
		w_held_ff <= 1'b0;
		w_data_ff <= `RESET_WORD;
		w_strb_ff <= `RESET_STRB;
		bvalid_ff <= 1'b0;
		bresp_ff <= `RESP_OKAY;
		irq_enable_ff <= `RESET_IRQ;
	end else begin
		aw_held_ff <= nxt_aw_held;
		aw_idx_ff <= nxt_aw_idx;
		w_held_ff <= nxt_w_held;
		w_data_ff <= nxt_w_data;
		w_strb_ff <= nxt_w_strb;
		bvalid_ff <= nxt_bvalid;
		bresp_ff <= nxt_bresp;
		irq_enable_ff <= nxt_irq_enable;
	end
end

// Read channel: one read in flight, answer one cycle after the address
assign ar_idx = s_axi_araddr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
assign s_axi_arready = ~rvalid_ff;
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;

always @* begin
	read_word = `RESET_WORD;
	read_hit = 1'b1;
	// Upper bits and reserved bits stay zero
	case (ar_idx)
		`IDX_CONFIG_PARITY_FAULT: read_word[`BYTE_MSB:`BYTE_LSB] = parity_value & `MASK_CONFIG_PARITY;
		`IDX_SELFTEST_FAULT: read_word[`BYTE_MSB:`BYTE_LSB] = selftest_value & `MASK_SELFTEST;
		`IDX_CELL_OVERVOLT_UPPER: read_word[`BYTE_MSB:`BYTE_LSB] = ov_upper_value;
		`IDX_CELL_OVERVOLT_LOWER: read_word[`BYTE_MSB:`BYTE_LSB] = ov_lower_value;
		`IDX_CELL_UNDERVOLT_UPPER: read_word[`BYTE_MSB:`BYTE_LSB] = uv_upper_value;
		`IDX_CELL_UNDERVOLT_LOWER: read_word[`BYTE_MSB:`BYTE_LSB] = uv_lower_value;
		`IDX_GPIO_OVERTEMP_STATUS: read_word[`BYTE_MSB:`BYTE_LSB] = ot_value;
		`IDX_IRQ_STATUS: read_word[`IRQ_MSB:`IRQ_LSB] = irq_status;
		`IDX_IRQ_ENABLE: read_word[`IRQ_MSB:`IRQ_LSB] = irq_enable_ff;
		`IDX_IRQ_CLEAR: read_word = `RESET_WORD;
		default: read_hit = 1'b0;
	endcase
end

// The answer stands until rready; arready stays low meanwhile
always @* begin
	nxt_rvalid = rvalid_ff;
	nxt_rdata = rdata_ff;
	nxt_rresp = rresp_ff;
	if (s_axi_arvalid && s_axi_arready) begin
		nxt_rvalid = 1'b1;
		nxt_rdata = read_word;
		nxt_rresp = read_hit ? `RESP_OKAY : `RESP_SLVERR;
	end else if (rvalid_ff && s_axi_rready) begin
		nxt_rvalid = 1'b0;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		rvalid_ff <= 1'b0;
		rdata_ff <= `RESET_WORD;
		rresp_ff <= `RESP_OKAY;
	end else begin
		rvalid_ff <= nxt_rvalid;
		rdata_ff <= nxt_rdata;
		rresp_ff <= nxt_rresp;
	end
end

endmodule // protection_fault_status_bank
`default_nettype wire

// File: dv/protection_fault_status_bank_properties.sv
`default_nettype none
`include "fault_bank_regs.vh"

module fault_bank_chk (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Write channels
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	// Read channels
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// Interrupt
	input wire irq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	AST_RST_IDLE: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
		else $error("bus or irq active after reset");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready high while rvalid");
	AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read data one cycle after address");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid stays after handshake");
	AST_R_RSVD: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
endmodule // fault_bank_chk

bind protection_fault_status_bank fault_bank_chk chk (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
`include "fault_bank_regs.vh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic vpe = 0, tpe = 0, sd = 0, sa = 0;
	logic [13:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic [5:0] se = 0;
	logic [15:0] ov = 0, uv = 0;
	logic [7:0] ot = 0;
	wire awr, wrd, bv, arr, rv, irq;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	int error_cnt = 0, n_checks = 0;

	always #5 aclk = ~aclk;

	protection_fault_status_bank dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.volt_cfg_parity_err(vpe), .temp_cfg_parity_err(tpe), .selftest_done(sd), .selftest_aborted(sa),
		.temp_path_err(se[5]), .volt_path_err(se[4]), .undertemp_cmp_err(se[3]), .overtemp_cmp_err(se[2]),
		.overvolt_cmp_err(se[1]), .undervolt_cmp_err(se[0]), .cell_overvolt_flag(ov),
		.cell_undervolt_flag(uv), .gpio_overtemp_flag(ot), .irq(irq));

	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Readies sampled mid-cycle; inputs are stable then, so no edge race
	task automatic xf(input bit w, input [11:0] i, input [31:0] d, output [31:0] q, output [1:0] r);
		bit ha, hw, hb, pb;
		int n;
		pb = 1;
		@(posedge aclk);
		awa <= {i, 2'b00};
		ara <= {i, 2'b00};
		wd <= d;
		awv <= w;
		wv <= w;
		bry <= w;
		arv <= !w;
		rry <= !w;
		for (n = 0; pb; n++) begin
			if (n == 50) begin
				error_cnt++;
				$display("Error bus response exp answer seen none");
				close_out;
			end
			@(negedge aclk);
			ha = w ? awr : arr;
			hw = wrd;
			hb = w ? bv : rv;
			q = rdat;
			r = w ? br : rr;
			@(posedge aclk);
			if (ha) begin
				awv <= 0;
				arv <= 0;
			end
			if (hw)
				wv <= 0;
			if (hb) begin
				pb = 0;
				bry <= 0;
				rry <= 0;
			end
		end
	endtask

	task automatic rd(input [11:0] i, input [1:0] er, input [31:0] e);
		logic [31:0] q;
		logic [1:0] r;
		xf(0, i, 32'h0, q, r);
		n_checks++;
		if ({r, q} !== {er, e}) begin
			error_cnt++;
			$display("Error read %h exp %h seen %h", i, {er, e}, {r, q});
		end
	endtask

	task automatic wr(input [11:0] i, input [31:0] d, input [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		xf(1, i, d, q, r);
		n_checks++;
		if (r !== er) begin
			error_cnt++;
			$display("Error bresp %h exp %h seen %h", i, er, r);
		end
	endtask

	task automatic ck_irq(input logic e);
		@(negedge aclk);
		n_checks++;
		if (irq !== e) begin
			error_cnt++;
			$display("Error irq exp %b seen %b", e, irq);
		end
	endtask

	task automatic pulse(input bit d, input bit a, input [5:0] v);
		@(posedge aclk);
		sd <= d;
		sa <= a;
		se <= v;
		@(posedge aclk);
		sd <= 0;
		sa <= 0;
		se <= 0;
	endtask

	task automatic t_reset;
		for (int k = 0; k < 7; k++)
			rd(`IDX_CONFIG_PARITY_FAULT + 12'(k), `RESP_OKAY, 32'h0);
	endtask

	task automatic t_parity;
		vpe <= 1;
		rd(`IDX_CONFIG_PARITY_FAULT, `RESP_OKAY, 32'h1);
		vpe <= 0;
		tpe <= 1;
		rd(`IDX_CONFIG_PARITY_FAULT, `RESP_OKAY, 32'h1 << `BIT_TEMP_CFG_PARITY);
		tpe <= 0;
	endtask

	task automatic t_cells;
		ov <= 16'hA501;
		uv <= 16'h0380;
		ot <= 8'h81;
		rd(`IDX_CELL_OVERVOLT_UPPER, `RESP_OKAY, 32'hA5);
		rd(`IDX_CELL_OVERVOLT_LOWER, `RESP_OKAY, 32'h01);
		rd(`IDX_CELL_UNDERVOLT_UPPER, `RESP_OKAY, 32'h03);
		rd(`IDX_CELL_UNDERVOLT_LOWER, `RESP_OKAY, 32'h80);
		rd(`IDX_GPIO_OVERTEMP_STATUS, `RESP_OKAY, 32'h81);
		ov <= 16'h0000;
		uv <= 16'h0000;
		ot <= 8'h00;
	endtask

	task automatic t_selftest;
		for (int k = 0; k < 6; k++) begin
			pulse(1, 0, 6'h01 << k);
			rd(`IDX_SELFTEST_FAULT, `RESP_OKAY, 32'h1 << k);
		end
		pulse(0, 1, 6'h00);
		rd(`IDX_SELFTEST_FAULT, `RESP_OKAY, 32'h40);
		pulse(1, 0, 6'h00);
		rd(`IDX_SELFTEST_FAULT, `RESP_OKAY, 32'h00);
		pulse(1, 1, 6'h00);
		rd(`IDX_SELFTEST_FAULT, `RESP_OKAY, 32'h40);
	endtask

	task automatic t_ro;
		// Self-test byte holds between runs, so a stored write would show
		wr(`IDX_SELFTEST_FAULT, 32'hFFFFFFFF, `RESP_OKAY);
		rd(`IDX_SELFTEST_FAULT, `RESP_OKAY, 32'h40);
		wr(12'h7FF, 32'h1, `RESP_SLVERR);
		rd(12'h7FF, `RESP_SLVERR, 32'h0);
	endtask

	// Sticky status must be cleared first: earlier runs left events behind
	task automatic t_irq;
		wr(`IDX_IRQ_CLEAR, 32'h7F, `RESP_OKAY);
		rd(`IDX_IRQ_STATUS, `RESP_OKAY, 32'h0);
		ov <= 16'h0001;
		// Sticky bit follows the flag register one edge later
		@(posedge aclk);
		rd(`IDX_IRQ_STATUS, `RESP_OKAY, 32'h1 << `IRQ_OV);
		ck_irq(0);
		wr(`IDX_IRQ_ENABLE, 32'h1 << `IRQ_OV, `RESP_OKAY);
		ck_irq(1);
		ov <= 16'h0000;
		wr(`IDX_IRQ_CLEAR, 32'h1 << `IRQ_OV, `RESP_OKAY);
		ck_irq(0);
		rd(`IDX_IRQ_ENABLE, `RESP_OKAY, 32'h1 << `IRQ_OV);
	endtask

	// Mid-run reset must drop latched results and interrupt setup
	task automatic t_reset2;
		pulse(0, 1, 6'h3F);
		rd(`IDX_SELFTEST_FAULT, `RESP_OKAY, 32'h7F);
		wr(`IDX_IRQ_ENABLE, 32'h7F, `RESP_OKAY);
		ck_irq(1);
		@(posedge aclk);
		aresetn <= 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(`IDX_SELFTEST_FAULT, `RESP_OKAY, 32'h0);
		rd(`IDX_IRQ_ENABLE, `RESP_OKAY, 32'h0);
		ck_irq(0);
	endtask

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_parity;
		t_cells;
		t_selftest;
		t_ro;
		t_irq;
		t_reset2;
		close_out;
	end
endmodule // tb
`default_nettype wire
